/* File: inc/err_count_pkg.sv */
package err_count_pkg;
  // Host port and counter widths
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  localparam int COUNT_W = 16;

  // Register byte addresses
  localparam logic [7:0] ADDR_CONFIG = 8'h41;
  localparam logic [7:0] ADDR_LINE_HIGH = 8'h42;
  localparam logic [7:0] ADDR_LINE_LOW = 8'h43;
  localparam logic [7:0] ADDR_PATH_HIGH = 8'h44;
  localparam logic [7:0] ADDR_PATH_LOW = 8'h45;

  // Reset values
  localparam logic [6:0] CONFIG_RESET = 7'h00;
  localparam logic [7:0] READ_IDLE = 8'h00;

  // Configuration field positions
  localparam int BIT_EXCESS_ZERO = 0;
  localparam int BIT_SYNC_LOSS = 1;
  localparam int BIT_FS_REPORT = 2;
  localparam int BIT_E1_CV = 3;
  localparam int BIT_ACC_MODE = 4;
  localparam int BIT_AUTO_INTERVAL = 5;
  localparam int BIT_MANUAL = 6;
  localparam int CONFIG_W = 7;

  // Counter limits
  localparam logic [15:0] COUNT_MAX = 16'hFFFF;

  // Update intervals in frames; one second holds 8000 frames of 125 us
  localparam logic [13:0] FRAMES_ONE_SECOND = 14'h1F40;
  localparam logic [13:0] FRAMES_T1_SHORT = 14'h014D;
  localparam logic [13:0] FRAMES_E1_SHORT = 14'h01F4;

  // Zero run lengths for excessive zero detection
  localparam logic [4:0] ZEROS_PLAIN = 5'h10;
  localparam logic [4:0] ZEROS_B8ZS = 5'h08;

  // Update source selection
  typedef enum logic [1:0] {
    UPD_AUTO = 2'b01,
    UPD_MANUAL = 2'b10
  } update_src_t;
endpackage

/* File: verilog/sat_counter.sv */
`timescale 1ns/1ns
module sat_counter
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic count_event,
  input wire logic latch,
  output logic [err_count_pkg::COUNT_W-1:0] snapshot
);
  import err_count_pkg::*;

  // Running count, never seen by the host directly
  logic [COUNT_W-1:0] running;
  // High while another increment would wrap
  wire at_max = (running == COUNT_MAX);
  // Value after one increment
  wire [COUNT_W-1:0] bumped = running + 16'h0001;
  // Count restarts at one if an event lands on the latch cycle, so it is not lost
  wire [COUNT_W-1:0] restart = count_event ? 16'h0001 : 16'h0000;
  wire [COUNT_W-1:0] next_running = latch ? restart : ((count_event && !at_max) ? bumped : running);

  // Running counter sticks at its top value
  always_ff @(posedge ref_clk)
  begin
    if (rst)
      running <= 16'h0000;
    else
      running <= next_running;
  end

  // Snapshot only moves on a latch, so reads stay coherent between updates
  always_ff @(posedge ref_clk)
  begin
    if (rst)
      snapshot <= 16'h0000;
    else if (latch)
      snapshot <= running;
  end
endmodule

/* File: verilog/update_timer.sv */
`timescale 1ns/1ns
module update_timer
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic frame_strobe,
  input wire logic [13:0] frame_limit,
  output logic boundary
);
  import err_count_pkg::*;

  // Frames seen since the last boundary
  logic [13:0] frames;
  // Last frame of the interval; a lowered limit also closes the interval at once
  wire last_frame = frame_strobe && (frames >= frame_limit - 14'h0001);
  wire [13:0] next_frames = last_frame ? 14'h0000 : (frame_strobe ? frames + 14'h0001 : frames);

  // Frame counter
  always_ff @(posedge ref_clk)
  begin
    if (rst)
      frames <= 14'h0000;
    else
      frames <= next_frames;
  end

  // One-cycle boundary pulse, registered
  always_ff @(posedge ref_clk)
  begin
    if (rst)
      boundary <= 1'b0;
    else
      boundary <= last_frame;
  end
endmodule

/* File: verilog/t1_e1_error_counters.sv */
`timescale 1ns/1ns
// Overview of operation
// - Counters saturate at maximum, never wrap
// - Mode bit picks automatic or manual updates
// - T1 auto latch: one second or 333 frames
// - E1 auto latch: one second or 500 frames
// - Manual bit rising edge latches and clears
// - Automatic boundaries raise the timer interrupt
// - T1 line: BPVs, optional zero runs, no codewords
// - T1 line counter ignores sync loss
// - E1 line: BPV or CV by select bit
// - E1 CV: same-polarity consecutive BPVs only
// - HDB3 codewords never counted as BPVs
// - E1 line counter ignores sync, saturates 65535
// - Sync-loss select bit: framing errors or MOS
// - T1 ESF path counts CRC6, ignores Fs bit
// - T1 D4 path counts Ft, Fs optional
// - T1 path counter halts during sync loss
// - E1 path counts CRC-4, FAS/CRC-4 sync gates
// - Counts split high byte first, low next
module t1_e1_error_counters
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [err_count_pkg::ADDR_W-1:0] host_addr,
  input wire logic host_write,
  input wire logic host_read,
  input wire logic [err_count_pkg::DATA_W-1:0] host_wdata,
  output logic [err_count_pkg::DATA_W-1:0] host_rdata,
  input wire logic mode_e1,
  input wire logic esf_mode,
  input wire logic b8zs_enable,
  input wire logic hdb3_enable,
  input wire logic bit_strobe,
  input wire logic rx_pos_mark,
  input wire logic rx_neg_mark,
  input wire logic codeword_violation,
  input wire logic frame_strobe,
  input wire logic receive_sync_lost,
  input wire logic fas_sync_lost,
  input wire logic crc4_sync_lost,
  input wire logic crc_error,
  input wire logic ft_error,
  input wire logic fs_error,
  output logic timer_interrupt,
  output logic sync_loss_count_select
);
  import err_count_pkg::*;

  // Configuration register, bit seven is not stored and reads zero
  logic [CONFIG_W-1:0] error_counter_config;
  // Manual bit as it stood one cycle ago, for edge detection
  logic manual_prev;
  // Latch command issued one cycle after the manual edge
  logic manual_latch;
  // Polarity of the most recent mark: 1 positive
  logic last_mark_pos;
  // Seen at least one mark since reset
  logic mark_seen;
  // Polarity of the most recent raw bipolar violation, excluded codewords included
  logic last_bpv_pos;
  // Seen at least one bipolar violation since reset
  logic bpv_seen;
  // Length of the current zero run, held once it reaches the threshold
  logic [4:0] zero_run;
  // Snapshots presented to the host
  logic [COUNT_W-1:0] line_violation_count;
  logic [COUNT_W-1:0] path_violation_count;

  // Named configuration fields
  wire excess_zero_count_select = error_counter_config[BIT_EXCESS_ZERO];
  wire fs_error_report_enable = error_counter_config[BIT_FS_REPORT];
  wire e1_code_violation_select = error_counter_config[BIT_E1_CV];
  wire accumulation_mode_select = error_counter_config[BIT_ACC_MODE];
  wire auto_interval_select = error_counter_config[BIT_AUTO_INTERVAL];
  wire manual_update_trigger = error_counter_config[BIT_MANUAL];

  // Update source
  wire update_src_t update_src = accumulation_mode_select ? UPD_MANUAL : UPD_AUTO;

  // Host decode
  wire config_write = host_write && (host_addr == ADDR_CONFIG);
  // Bit seven is dropped here; the host is expected to write it as zero anyway
  wire [CONFIG_W-1:0] next_config = config_write ? host_wdata[CONFIG_W-1:0] : error_counter_config;

  // Configuration register
  always_ff @(posedge ref_clk)
  begin
    if (rst)
      error_counter_config <= CONFIG_RESET;
    else
      error_counter_config <= next_config;
  end

  // Manual update: a zero-to-one change of the trigger bit, only in manual mode
  wire manual_edge = manual_update_trigger && !manual_prev && (update_src == UPD_MANUAL);

  // Edge history and the one-cycle-later latch command
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      manual_prev <= 1'b0;
      manual_latch <= 1'b0;
    end
    else
    begin
      manual_prev <= manual_update_trigger;
      manual_latch <= manual_edge;
    end
  end

  // Interval length depends on line standard and interval select
  wire [13:0] short_frames = mode_e1 ? FRAMES_E1_SHORT : FRAMES_T1_SHORT;
  wire [13:0] frame_limit = auto_interval_select ? short_frames : FRAMES_ONE_SECOND;
  // One-cycle pulse at each interval end
  wire interval_end;

  update_timer timer_unit
  (
    .ref_clk(ref_clk),
    .rst(rst),
    .frame_strobe(frame_strobe),
    .frame_limit(frame_limit),
    .boundary(interval_end)
  );

  // Automatic boundaries count only when automatic mode is selected
  wire auto_latch = interval_end && (update_src == UPD_AUTO);
  // Either source latches both counters together
  wire latch_now = auto_latch || manual_latch;

  // Timer interrupt pulse, one cycle, aligned with the fresh snapshot
  always_ff @(posedge ref_clk)
  begin
    if (rst)
      timer_interrupt <= 1'b0;
    else
      timer_interrupt <= auto_latch;
  end

  // Mode bit shared with the frames-out-of-sync counter, passed on as is
  always_ff @(posedge ref_clk)
  begin
    if (rst)
      sync_loss_count_select <= 1'b0;
    else
      sync_loss_count_select <= error_counter_config[BIT_SYNC_LOSS];
  end

  // Line decoding
  wire is_mark = bit_strobe && (rx_pos_mark ^ rx_neg_mark);
  wire is_zero = bit_strobe && !rx_pos_mark && !rx_neg_mark;
  // Same polarity as the previous mark
  wire raw_bpv = is_mark && mark_seen && (rx_pos_mark == last_mark_pos);
  // Substitution codewords are excluded when the matching code is on
  wire codeword_excluded = codeword_violation && (mode_e1 ? hdb3_enable : b8zs_enable);
  wire bpv = raw_bpv && !codeword_excluded;
  // E1 code violation: two successive violations of the same polarity
  wire code_violation = raw_bpv && bpv_seen && (rx_pos_mark == last_bpv_pos);

  // Mark and violation polarity history
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      last_mark_pos <= 1'b0;
      mark_seen <= 1'b0;
      last_bpv_pos <= 1'b0;
      bpv_seen <= 1'b0;
    end
    else
    begin
      if (is_mark)
      begin
        last_mark_pos <= rx_pos_mark;
        mark_seen <= 1'b1;
      end
      if (raw_bpv)
      begin
        last_bpv_pos <= rx_pos_mark;
        bpv_seen <= 1'b1;
      end
    end
  end

  // Excessive zeros: threshold shorter when B8ZS is on
  wire [4:0] zero_limit = b8zs_enable ? ZEROS_B8ZS : ZEROS_PLAIN;
  // One count per run, as the run first reaches the threshold
  wire zero_hit = is_zero && (zero_run == zero_limit - 5'h01);
  wire [4:0] next_zero_run = is_mark ? 5'h00 : ((is_zero && zero_run < zero_limit) ? zero_run + 5'h01 : zero_run);

  // Zero run length
  always_ff @(posedge ref_clk)
  begin
    if (rst)
      zero_run <= 5'h00;
    else
      zero_run <= next_zero_run;
  end

  // Line event by standard; no sync gating on either path
  wire t1_line_event = bpv || (excess_zero_count_select && zero_hit);
  wire e1_line_event = e1_code_violation_select ? code_violation : bpv;
  wire line_event = mode_e1 ? e1_line_event : t1_line_event;

  // Path event: ESF CRC6, D4 Ft with optional Fs, E1 CRC-4
  wire t1_frame_error = ft_error || (fs_error_report_enable && fs_error);
  wire t1_path_raw = esf_mode ? crc_error : t1_frame_error;
  wire t1_path_event = t1_path_raw && !receive_sync_lost;
  // CAS multiframe loss is not an input here, so it cannot gate the count
  wire e1_path_event = crc_error && !fas_sync_lost && !crc4_sync_lost;
  wire path_event = mode_e1 ? e1_path_event : t1_path_event;

  sat_counter line_counter
  (
    .ref_clk(ref_clk),
    .rst(rst),
    .count_event(line_event),
    .latch(latch_now),
    .snapshot(line_violation_count)
  );

  sat_counter path_counter
  (
    .ref_clk(ref_clk),
    .rst(rst),
    .count_event(path_event),
    .latch(latch_now),
    .snapshot(path_violation_count)
  );

  // Read mux: high byte at the lower address
  wire [7:0] config_read = {1'b0, error_counter_config};
  wire [7:0] read_value =
    (host_addr == ADDR_CONFIG) ? config_read :
    (host_addr == ADDR_LINE_HIGH) ? line_violation_count[15:8] :
    (host_addr == ADDR_LINE_LOW) ? line_violation_count[7:0] :
    (host_addr == ADDR_PATH_HIGH) ? path_violation_count[15:8] :
    (host_addr == ADDR_PATH_LOW) ? path_violation_count[7:0] :
    READ_IDLE;

  // Registered read data; the snapshot is ready two edges after a manual write,
  // which is why the host waits before reading
  always_ff @(posedge ref_clk)
  begin
    if (rst)
      host_rdata <= READ_IDLE;
    else if (host_read)
      host_rdata <= read_value;
  end
endmodule

/* File: sim/t1_e1_error_counters_checker.sv */
`timescale 1ns/1ns
module t1_e1_error_counters_checker
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [7:0] host_addr,
  input wire logic host_write,
  input wire logic host_read,
  input wire logic [7:0] host_wdata,
  input wire logic [7:0] host_rdata,
  input wire logic frame_strobe,
  input wire logic timer_interrupt,
  input wire logic sync_loss_count_select
);
  import err_count_pkg::*;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  logic [6:0] cfg; // Shadow of the configuration byte
  wire mapped = host_addr >= ADDR_CONFIG && host_addr <= ADDR_PATH_LOW; // Address hits a register

  // Shadow copy lets reads and mode checks be predicted without the design's state
  always_ff @(posedge ref_clk)
  begin
    if (rst)
      cfg <= 7'h00;
    else if (host_write && host_addr == ADDR_CONFIG)
      cfg <= host_wdata[6:0];
  end

  property p_cfg_read; host_read && host_addr == ADDR_CONFIG |=> host_rdata == {1'b0, $past(cfg)}; endproperty
  a_cfg_read: assert property (p_cfg_read) else $error("config readback wrong");
  property p_unmapped; host_read && !mapped |=> host_rdata == READ_IDLE; endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_rdata_hold; !host_read |=> $stable(host_rdata); endproperty
  a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved without a read");
  property p_irq_cause; timer_interrupt |-> $past(frame_strobe, 2); endproperty
  a_irq_cause: assert property (p_irq_cause) else $error("interrupt without a frame");
  property p_irq_gap; timer_interrupt |=> !timer_interrupt [*8]; endproperty
  a_irq_gap: assert property (p_irq_gap) else $error("interrupts too close");
  // Three settled cycles of manual mode, so a boundary already in flight is excused
  property p_manual_quiet; cfg[4] && $past(cfg[4]) && $past(cfg[4], 2) |-> !timer_interrupt; endproperty
  a_manual_quiet: assert property (p_manual_quiet) else $error("interrupt in manual mode");
  property p_sel_copy; sync_loss_count_select == $past(cfg[1]); endproperty
  a_sel_copy: assert property (p_sel_copy) else $error("select output wrong");
  property p_reset; $fell(rst) |-> host_rdata == READ_IDLE && !timer_interrupt; endproperty
  a_reset: assert property (p_reset) else $error("outputs not clear after reset");

  c_irq: cover property (timer_interrupt);
  c_unmapped: cover property (host_read && !mapped);
  c_manual: cover property ($rose(cfg[6]) && cfg[4]);
endmodule

bind t1_e1_error_counters t1_e1_error_counters_checker u_chk (.ref_clk, .rst, .host_addr, .host_write,
  .host_read, .host_wdata, .host_rdata, .frame_strobe, .timer_interrupt, .sync_loss_count_select);

/* File: sim/rx_framer_model.sv */
`timescale 1ns/1ns
module rx_framer_model
(
  input wire logic ref_clk,
  output logic bit_strobe,
  output logic rx_pos_mark,
  output logic rx_neg_mark,
  output logic codeword_violation,
  output logic frame_strobe,
  output logic crc_error,
  output logic ft_error,
  output logic fs_error
);
  // Idle receiver at time zero
  initial
  begin
    {bit_strobe, rx_pos_mark, rx_neg_mark, codeword_violation, frame_strobe, crc_error, ft_error, fs_error} = '0;
  end

  // One cycle of decoder output; marks scramble between bits so stale levels never look valid
  task automatic drive(input logic [7:0] v);
    @(negedge ref_clk);
    {bit_strobe, rx_pos_mark, rx_neg_mark, codeword_violation, frame_strobe, crc_error, ft_error, fs_error} = v;
    if (!v[7])
      {rx_pos_mark, rx_neg_mark} = 2'($urandom);
  endtask
endmodule

/* File: sim/t1_e1_error_counters_tb.sv */
`timescale 1ns/1ns
module t1_e1_error_counters_tb;
  import err_count_pkg::*;
  // Decoder words: strobe, pos, neg, codeword, frame, crc, ft, fs
  localparam logic [7:0] P = 8'hC0, N = 8'hA0, Z = 8'h80, PC = 8'hD0, F = 8'h08, CR = 8'h04, FT = 8'h02, FS = 8'h01;
  logic ref_clk, rst, host_write, host_read, mode_e1, esf_mode, b8zs_enable, hdb3_enable;
  logic receive_sync_lost, fas_sync_lost, crc4_sync_lost, timer_interrupt, sync_loss_count_select;
  logic bit_strobe, rx_pos_mark, rx_neg_mark, codeword_violation, frame_strobe, crc_error, ft_error, fs_error;
  logic [7:0] host_addr, host_wdata, host_rdata;
  logic [15:0] exp_q[$]; // Address and expected byte of each read
  logic rd_seen; // Read answer due this cycle
  int bad_count, n_compared, n;

  t1_e1_error_counters u_dut (.ref_clk, .rst, .host_addr, .host_write, .host_read, .host_wdata, .host_rdata,
    .mode_e1, .esf_mode, .b8zs_enable, .hdb3_enable, .bit_strobe, .rx_pos_mark, .rx_neg_mark,
    .codeword_violation, .frame_strobe, .receive_sync_lost, .fas_sync_lost, .crc4_sync_lost, .crc_error,
    .ft_error, .fs_error, .timer_interrupt, .sync_loss_count_select);
  rx_framer_model u_rx (.ref_clk, .bit_strobe, .rx_pos_mark, .rx_neg_mark, .codeword_violation,
    .frame_strobe, .crc_error, .ft_error, .fs_error);

  // Free running clock, 50 ns period
  initial
  begin
    ref_clk = 0;
    forever #25 ref_clk = ~ref_clk;
  end

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic stop_test;
    $display("compared %0d mismatched %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // Read data is registered, so the answer is checked one edge after the read is taken
  always @(posedge ref_clk) rd_seen <= host_read;
  always @(negedge ref_clk)
  begin
    if (rd_seen)
    begin
      check($sformatf("reg %h", exp_q[0][15:8]), {8'h00, host_rdata}, {8'h00, exp_q[0][7:0]});
      void'(exp_q.pop_front());
    end
  end

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge ref_clk);
    {host_addr, host_wdata, host_write} = {a, d, 1'b1};
    @(negedge ref_clk);
    host_write = 0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(negedge ref_clk);
    {host_addr, host_read} = {a, 1'b1};
    exp_q.push_back({a, e});
    @(negedge ref_clk);
    host_read = 0;
  endtask

  // Clear the trigger first so the second write is a true rising edge
  task automatic latch(input logic [7:0] c);
    wr(ADDR_CONFIG, c);
    wr(ADDR_CONFIG, c | 8'h40);
    repeat (2) @(negedge ref_clk);
  endtask

  task automatic counts(input logic [15:0] line, input logic [15:0] path);
    rd(ADDR_LINE_HIGH, line[15:8]);
    rd(ADDR_LINE_LOW, line[7:0]);
    rd(ADDR_PATH_HIGH, path[15:8]);
    rd(ADDR_PATH_LOW, path[7:0]);
  endtask

  task automatic play(input logic [7:0] s[$]);
    foreach (s[i])
      u_rx.drive(s[i]);
    u_rx.drive(8'h00);
  endtask

  // Frames every cycle; n ends as the cycle gap to the next interrupt
  task automatic wait_irq;
    n = 0;
    do
    begin
      u_rx.drive(F);
      n++;
    end
    while (timer_interrupt !== 1'b1 && n < 9000);
    if (n >= 9000)
    begin
      bad_count++;
      stop_test();
    end
  endtask

  initial
  begin
    {rst, host_write, host_read, mode_e1, esf_mode, b8zs_enable, hdb3_enable} = 7'h40;
    {receive_sync_lost, fas_sync_lost, crc4_sync_lost, host_addr, host_wdata} = '0;
    void'($urandom(32'h6282));
    // Reset spans three rising edges and is dropped on a falling edge, away from any rising edge
    repeat (3) @(posedge ref_clk);
    @(negedge ref_clk);
    rst = 0;
    for (int a = 8'h41; a < 8'h47; a++)
      rd(8'(a), 8'h00);
    wr(ADDR_CONFIG, 8'hFF);
    rd(ADDR_CONFIG, 8'h7F);
    $display("test reset done");
    wr(ADDR_CONFIG, 8'h11);
    play('{P, P});
    repeat (16) u_rx.drive(Z);
    receive_sync_lost = 1;
    play('{N, N, FT});
    receive_sync_lost = 0;
    play('{FT, FS});
    latch(8'h11);
    counts(16'h0003, 16'h0001);
    $display("test t1 line done");
    b8zs_enable = 1;
    wr(ADDR_CONFIG, 8'h17);
    play('{P, PC});
    repeat (8) u_rx.drive(Z);
    play('{N, FT, FS});
    latch(8'h17);
    counts(16'h0001, 16'h0002);
    check("select", {15'h0, sync_loss_count_select}, 16'h0001);
    $display("test t1 b8zs done");
    {mode_e1, hdb3_enable, b8zs_enable} = 3'b110;
    wr(ADDR_CONFIG, 8'h10);
    play('{P, PC, N, N, CR});
    fas_sync_lost = 1;
    play('{CR});
    {fas_sync_lost, crc4_sync_lost} = 2'b01;
    play('{CR});
    crc4_sync_lost = 0;
    latch(8'h10);
    counts(16'h0001, 16'h0001);
    wr(ADDR_CONFIG, 8'h18);
    play('{P, P, N, P, P});
    latch(8'h18);
    counts(16'h0001, 16'h0000);
    $display("test e1 done");
    {mode_e1, esf_mode, hdb3_enable} = 3'b010;
    // Short interval chosen while in manual mode: a boundary passes, yet no interrupt or latch may follow
    wr(ADDR_CONFIG, 8'h34);
    repeat (340) u_rx.drive(F);
    play('{CR, FS, FT, CR});
    latch(8'h34);
    counts(16'h0000, 16'h0002);
    $display("test esf done");
    mode_e1 = 1;
    wr(ADDR_CONFIG, 8'h10);
    repeat (65540) u_rx.drive(P);
    u_rx.drive(8'h00);
    latch(8'h10);
    counts(16'hFFFF, 16'h0000);
    $display("test saturate done");
    for (int i = 0; i < 3; i++)
    begin
      mode_e1 = (i == 1);
      wr(ADDR_CONFIG, i < 2 ? 8'h20 : 8'h00);
      wait_irq();
      wait_irq();
      check("interval", 16'(n), i == 0 ? 16'd333 : i == 1 ? 16'd500 : 16'd8000);
    end
    u_rx.drive(8'h00);
    $display("test auto done");
    repeat (2) @(negedge ref_clk);
    stop_test();
  end
endmodule
